/* File: rtl/sfpu_consts.vh */
// Constants shared by the store-forward and prefetch unit
`ifndef SFPU_CONSTS_VH
`define SFPU_CONSTS_VH
`define SFPU_ADDR_W 48
`define SFPU_DATA_W 64
`define SFPU_SB_DEPTH 4
`define SFPU_PF_MAX 8
`define SFPU_LINE_BYTES 64
`define SFPU_HW_DIST 3
`define SFPU_DEP_HI 11
`define SFPU_DEP_LO 2
`define SFPU_SZ_BYTE 2'h0
`define SFPU_SZ_WORD 2'h1
`define SFPU_SZ_DWORD 2'h2
`define SFPU_SZ_QWORD 2'h3
`define SFPU_OP_LOAD 3'h0
`define SFPU_OP_HINT0 3'h1
`define SFPU_OP_HINT1 3'h2
`define SFPU_OP_HINT2 3'h3
`define SFPU_OP_MODIFY 3'h4
`define SFPU_OP_NTA 3'h5
`define SFPU_OP_HW 3'h6
`endif

/* File: rtl/sfpu_fwd_check.v */
// Dependency and forwarding check of one load against one store entry
`timescale 1ns/1ps
`include "sfpu_consts.vh"
module sfpu_fwd_check #(
  parameter ADDR_W = `SFPU_ADDR_W
) (
  // Load under test
  input wire [ADDR_W-1:0] ldAddr,
  input wire [1:0] ldSize,
  // Store entry
  input wire [ADDR_W-1:0] stAddr,
  input wire [1:0] stSize,
  input wire stHighByte,
  // Verdict
  output wire depends,
  output wire canForward
);

  // Natural alignment for 1, 2, 4 or 8 byte operands
  function isAligned;
    input [2:0] low;
    input [1:0] size;
    begin
      case (size)
        `SFPU_SZ_BYTE: isAligned = 1'h1;
        `SFPU_SZ_WORD: isAligned = (low[0] == 1'h0);
        `SFPU_SZ_DWORD: isAligned = (low[1:0] == 2'h0);
        default: isAligned = (low == 3'h0);
      endcase
    end
  endfunction

  function [ADDR_W:0] endOf;
    input [ADDR_W-1:0] a;
    input [1:0] size;
    begin
      endOf = {1'h0, a} + ({{ADDR_W{1'h0}}, 1'h1} << size);
    end
  endfunction

  wire partialMatch;
  wire trueOverlap;
  wire sameStart;
  wire bothAligned;

  // Only bits 11..2 are compared, so a store a whole number of pages
  // away, or elsewhere in the same doubleword, still matches
  assign partialMatch = (ldAddr[`SFPU_DEP_HI:`SFPU_DEP_LO] ==
                         stAddr[`SFPU_DEP_HI:`SFPU_DEP_LO]);
  // Real byte overlap catches loads straddling into the store
  assign trueOverlap = ({1'h0, ldAddr} < endOf(stAddr, stSize)) &&
                       ({1'h0, stAddr} < endOf(ldAddr, ldSize));
  assign depends = partialMatch | trueOverlap;

  // Forwarding needs equal starts, load no wider, both aligned, low byte source
  assign sameStart = (ldAddr == stAddr);
  assign bothAligned = isAligned(ldAddr[2:0], ldSize) &&
                       isAligned(stAddr[2:0], stSize);
  assign canForward = trueOverlap && sameStart && bothAligned &&
                      (ldSize <= stSize) &&
                      !stHighByte;

endmodule

/* File: rtl/sfpu_unit.v */
// Store-to-load forwarding, software and hardware prefetch unit
// Notes on behaviour
// - Refuse forwarding narrow store inside wider load
// - Refuse wider store when start addresses differ
// - Refuse forwarding if either access misaligned
// - Refuse forwarding from upper-byte register data
// - Aligned quadword store feeds same-address doubleword load
// - Dependency compares address bits 11..2, or true byte overlap
// - Stores whole pages away may falsely match
// - Prefetch requests whole line holding address
// - Load prefetches fill first-level cache
// - Modify-intent prefetch fills line already modified
// - Nontemporal prefetch fills way 0, never second-level
// - Prefetch ignores emulation and task-switched bits
// - Prefetch writes no architectural register
// - Lines l then l+1 launch line l+3
// - Hardware prefetches go to second-level cache
// - No trigger on descending or skipping patterns
// - Line size is a parameter, 64 bytes
// - At most eight outstanding prefetch requests
// - Stall next request while resources full
// - Pending prefetches serviced in issue order
// - Streaming stores go to write-combining, no read
// - Forward only on all four conditions
// - Refused load waits for store retirement
`timescale 1ns/1ps
`include "sfpu_consts.vh"
module sfpu_unit #(
  parameter ADDR_W = `SFPU_ADDR_W,
  parameter DATA_W = `SFPU_DATA_W,
  parameter SB_DEPTH = `SFPU_SB_DEPTH,
  parameter PF_MAX = `SFPU_PF_MAX,
  parameter LINE_BYTES = `SFPU_LINE_BYTES
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Store issue
  input wire stIssueValid,
  input wire [ADDR_W-1:0] stIssueAddr,
  input wire [1:0] stIssueSize,
  input wire stIssueHighByte,
  input wire stIssueStreaming,
  input wire [DATA_W-1:0] stIssueData,
  output reg stReady,
  // Store retire
  input wire stRetire,
  // Data cache write
  output reg dcWrValid,
  output reg [ADDR_W-1:0] dcWrAddr,
  output reg [1:0] dcWrSize,
  output reg [DATA_W-1:0] dcWrData,
  // Write-combining write
  output reg wcWrValid,
  output reg [ADDR_W-1:0] wcWrAddr,
  output reg [1:0] wcWrSize,
  output reg [DATA_W-1:0] wcWrData,
  // Load request and answer
  input wire ldValid,
  input wire [ADDR_W-1:0] ldAddr,
  input wire [1:0] ldSize,
  output reg ldReady,
  output reg ldDoneValid,
  output reg ldDoneForward,
  output reg [DATA_W-1:0] ldDoneData,
  // Software prefetch
  input wire pfValid,
  input wire [2:0] pfOp,
  input wire [ADDR_W-1:0] pfAddr,
  output reg pfReady,
  // Demand access stream for the hardware prefetcher
  input wire accValid,
  input wire [ADDR_W-1:0] accAddr,
  // Memory request path
  output reg memReqValid,
  output reg [ADDR_W-1:0] memReqAddr,
  output reg memReqToL2,
  output reg memReqModified,
  output reg memReqWay0,
  output reg memReqNoL2Evict,
  input wire memReqReady,
  input wire memDone
);

  function integer clog2;
    input integer v;
    begin
      clog2 = 0;
      while ((1 << clog2) < v) begin
        clog2 = clog2 + 1;
      end
    end
  endfunction
  localparam LINE_SHIFT = clog2(LINE_BYTES);
  localparam LINE_W = ADDR_W - LINE_SHIFT;
  localparam SB_PW = (SB_DEPTH > 1) ? clog2(SB_DEPTH) : 1;
  localparam PF_PW = (PF_MAX > 1) ? clog2(PF_MAX) : 1;
  localparam SB_CW = clog2(SB_DEPTH + 1);
  localparam PF_CW = clog2(PF_MAX + 1);
  // Keep only the bytes a load of this size reads
  function [DATA_W-1:0] maskData;
    input [DATA_W-1:0] d;
    input [1:0] size;
    begin
      case (size)
        `SFPU_SZ_BYTE: maskData = d & {{(DATA_W-8){1'h0}}, 8'hFF};
        `SFPU_SZ_WORD: maskData = d & {{(DATA_W-16){1'h0}}, 16'hFFFF};
        `SFPU_SZ_DWORD: maskData = d & {{(DATA_W-32){1'h0}}, 32'hFFFFFFFF};
        default: maskData = d;
      endcase
    end
  endfunction
  // Store buffer, oldest at sbHead
  reg [ADDR_W-1:0] sbAddr [0:SB_DEPTH-1];
  reg [1:0] sbSize [0:SB_DEPTH-1];
  reg [DATA_W-1:0] sbData [0:SB_DEPTH-1];
  reg sbHigh [0:SB_DEPTH-1];
  reg sbStream [0:SB_DEPTH-1];
  reg [SB_PW-1:0] sbHead;
  reg [SB_PW-1:0] sbTail;
  reg [SB_CW-1:0] sbCount;
  // Load blocked behind a store entry
  reg ldWaiting;
  reg [SB_PW-1:0] ldWaitIdx;
  // Prefetch queue: entries live from issue until memDone
  reg [ADDR_W-1:0] pfqAddr [0:PF_MAX-1];
  reg [2:0] pfqOp [0:PF_MAX-1];
  reg [PF_PW-1:0] pfqSend;
  reg [PF_PW-1:0] pfqTail;
  reg [PF_CW-1:0] pfqCount;
  reg [PF_CW-1:0] pfqUnsent;
  // Hardware stream detector
  reg [LINE_W-1:0] lastLine;
  reg lastValid;
  reg hwPend;
  reg [LINE_W-1:0] hwLine;
  wire [SB_DEPTH-1:0] depVec;
  wire [SB_DEPTH-1:0] fwdVec;
  genvar g;
  generate
    for (g = 0; g < SB_DEPTH; g = g + 1) begin : gChk
      sfpu_fwd_check #(.ADDR_W(ADDR_W)) uChk (
        .ldAddr(ldAddr),
        .ldSize(ldSize),
        .stAddr(sbAddr[g]),
        .stSize(sbSize[g]),
        .stHighByte(sbHigh[g]),
        .depends(depVec[g]),
        .canForward(fwdVec[g])
      );
    end
  endgenerate
  // Walk oldest to youngest; last hit wins so the youngest store decides
  reg hitAny;
  reg hitFwd;
  reg [SB_PW-1:0] hitIdx;
  integer i;
  integer pos;
  always @* begin
    hitAny = 1'h0;
    hitFwd = 1'h0;
    hitIdx = {SB_PW{1'h0}};
    pos = 0;
    for (i = 0; i < SB_DEPTH; i = i + 1) begin
      pos = sbHead + i;
      if (pos >= SB_DEPTH) begin
        pos = pos - SB_DEPTH;
      end
      if (i < sbCount && depVec[pos]) begin
        hitAny = 1'h1;
        hitFwd = fwdVec[pos];
        hitIdx = pos[SB_PW-1:0];
      end
    end
  end
  wire stTake = stIssueValid && stReady;
  wire stPop = stRetire && (sbCount != {SB_CW{1'h0}});
  wire ldTake = ldValid && ldReady;
  wire [SB_CW-1:0] next_sbCount = sbCount + {{(SB_CW-1){1'h0}}, stTake}
                                  - {{(SB_CW-1){1'h0}}, stPop};
  wire ldRelease = ldWaiting && stPop && (sbHead == ldWaitIdx);
  // Store buffer fill, retire and the cache or write-combining write
  always @(posedge sys_clk) begin
    if (reset) begin
      sbHead <= {SB_PW{1'h0}};
      sbTail <= {SB_PW{1'h0}};
      sbCount <= {SB_CW{1'h0}};
      stReady <= 1'h0;
      dcWrValid <= 1'h0;
      wcWrValid <= 1'h0;
      dcWrAddr <= {ADDR_W{1'h0}};
      dcWrSize <= 2'h0;
      dcWrData <= {DATA_W{1'h0}};
      wcWrAddr <= {ADDR_W{1'h0}};
      wcWrSize <= 2'h0;
      wcWrData <= {DATA_W{1'h0}};
    end else begin
      if (stTake) begin
        sbAddr[sbTail] <= stIssueAddr;
        sbSize[sbTail] <= stIssueSize;
        sbData[sbTail] <= stIssueData;
        sbHigh[sbTail] <= stIssueHighByte;
        sbStream[sbTail] <= stIssueStreaming;
        sbTail <= (sbTail == SB_DEPTH - 1) ? {SB_PW{1'h0}} : sbTail + 1'h1;
      end
      // Streaming stores skip the cache and never read the line
      dcWrValid <= stPop && !sbStream[sbHead];
      wcWrValid <= stPop && sbStream[sbHead];
      if (stPop) begin
        dcWrAddr <= sbAddr[sbHead];
        dcWrSize <= sbSize[sbHead];
        dcWrData <= sbData[sbHead];
        wcWrAddr <= sbAddr[sbHead];
        wcWrSize <= sbSize[sbHead];
        wcWrData <= sbData[sbHead];
        sbHead <= (sbHead == SB_DEPTH - 1) ? {SB_PW{1'h0}} : sbHead + 1'h1;
      end
      sbCount <= next_sbCount;
      stReady <= (next_sbCount < SB_DEPTH);
    end
  end

  // Load verdict, registered one cycle after the load is taken
  always @(posedge sys_clk) begin
    if (reset) begin
      ldWaiting <= 1'h0;
      ldWaitIdx <= {SB_PW{1'h0}};
      ldReady <= 1'h0;
      ldDoneValid <= 1'h0;
      ldDoneForward <= 1'h0;
      ldDoneData <= {DATA_W{1'h0}};
    end else begin
      ldDoneValid <= 1'h0;
      ldDoneForward <= 1'h0;
      if (ldRelease) begin
        // Data now sits in the cache; the load reads it there
        ldWaiting <= 1'h0;
        ldReady <= 1'h1;
        ldDoneValid <= 1'h1;
      end else if (ldTake) begin
        if (!hitAny) begin
          ldDoneValid <= 1'h1;
        end else if (hitFwd) begin
          ldDoneValid <= 1'h1;
          ldDoneForward <= 1'h1;
          ldDoneData <= maskData(sbData[hitIdx], ldSize);
        end else begin
          // Refused or false match: hold the load and stop new ones
          ldWaiting <= 1'h1;
          ldWaitIdx <= hitIdx;
          ldReady <= 1'h0;
        end
      end else if (!ldWaiting) begin
        ldReady <= 1'h1;
      end
    end
  end
  // Stream detector: only an ascending step of exactly one line triggers
  wire [LINE_W-1:0] accLine = accAddr[ADDR_W-1:LINE_SHIFT];
  wire stepUp = lastValid && (accLine == lastLine + 1'h1);
  wire pfTake = pfValid && pfReady;
  wire hwTake = hwPend && !pfTake && (pfqCount < PF_MAX);
  wire sendFire = (!memReqValid || memReqReady) &&
                  (pfqUnsent != {PF_CW{1'h0}});
  wire pfqPush = pfTake || hwTake;
  wire pfqPop = memDone && (pfqCount != {PF_CW{1'h0}});
  wire [PF_CW-1:0] next_pfqCount = pfqCount + {{(PF_CW-1){1'h0}}, pfqPush}
                                   - {{(PF_CW-1){1'h0}}, pfqPop};
  always @(posedge sys_clk) begin
    if (reset) begin
      lastLine <= {LINE_W{1'h0}};
      lastValid <= 1'h0;
      hwPend <= 1'h0;
      hwLine <= {LINE_W{1'h0}};
    end else begin
      if (accValid) begin
        lastLine <= accLine;
        lastValid <= 1'h1;
      end
      // Current access is l+1, so the target is l+3
      if (accValid && stepUp) begin
        hwPend <= 1'h1;
        hwLine <= lastLine + `SFPU_HW_DIST;
      end else if (hwTake) begin
        hwPend <= 1'h0;
      end
    end
  end
  // Prefetch queue; one push per cycle, software ahead of hardware
  always @(posedge sys_clk) begin
    if (reset) begin
      pfqSend <= {PF_PW{1'h0}};
      pfqTail <= {PF_PW{1'h0}};
      pfqCount <= {PF_CW{1'h0}};
      pfqUnsent <= {PF_CW{1'h0}};
      pfReady <= 1'h0;
    end else begin
      if (pfqPush) begin
        // Line-aligned address: the whole line is requested
        pfqAddr[pfqTail] <= pfTake ?
          {pfAddr[ADDR_W-1:LINE_SHIFT], {LINE_SHIFT{1'h0}}} :
          {hwLine, {LINE_SHIFT{1'h0}}};
        pfqOp[pfqTail] <= pfTake ? pfOp : `SFPU_OP_HW;
        pfqTail <= (pfqTail == PF_MAX - 1) ? {PF_PW{1'h0}} : pfqTail + 1'h1;
      end
      if (sendFire) begin
        pfqSend <= (pfqSend == PF_MAX - 1) ? {PF_PW{1'h0}} : pfqSend + 1'h1;
      end
      pfqUnsent <= pfqUnsent + {{(PF_CW-1){1'h0}}, pfqPush}
                   - {{(PF_CW-1){1'h0}}, sendFire};
      pfqCount <= next_pfqCount;
      // Full counts in-flight entries too, so a ninth request waits
      pfReady <= (next_pfqCount < PF_MAX);
    end
  end
  // Memory request register, drained strictly in queue order
  always @(posedge sys_clk) begin
    if (reset) begin
      memReqValid <= 1'h0;
      memReqAddr <= {ADDR_W{1'h0}};
      memReqToL2 <= 1'h0;
      memReqModified <= 1'h0;
      memReqWay0 <= 1'h0;
      memReqNoL2Evict <= 1'h0;
    end else if (sendFire) begin
      memReqValid <= 1'h1;
      memReqAddr <= pfqAddr[pfqSend];
      // Software kinds fill L1 only and write back no register
      memReqToL2 <= (pfqOp[pfqSend] == `SFPU_OP_HW);
      memReqModified <= (pfqOp[pfqSend] == `SFPU_OP_MODIFY);
      memReqWay0 <= (pfqOp[pfqSend] == `SFPU_OP_NTA);
      memReqNoL2Evict <= (pfqOp[pfqSend] == `SFPU_OP_NTA);
    end else if (memReqReady) begin
      memReqValid <= 1'h0;
    end
  end

endmodule

/* File: verification/sfpu_unit_monitor.sv */
// Assertion checker for the store-forward and prefetch unit
`timescale 1ns/1ps
module sfpu_unit_monitor #(
  parameter ADDR_W = 48,
  parameter PF_MAX = 8
) (
  // Clock, reset and store side
  input wire sys_clk,
  input wire reset,
  input wire stRetire,
  input wire dcWrValid,
  input wire wcWrValid,
  // Load answer
  input wire ldDoneValid,
  input wire ldDoneForward,
  // Memory request path
  input wire memReqValid,
  input wire [ADDR_W-1:0] memReqAddr,
  input wire memReqToL2,
  input wire memReqModified,
  input wire memReqWay0,
  input wire memReqNoL2Evict,
  input wire memReqReady,
  input wire memDone
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Sent but not done; queued requests are not seen here
  reg [4:0] inFlight;
  always @(posedge sys_clk) begin
    if (reset) inFlight <= 5'h00;
    else inFlight <= inFlight + {4'h0, memReqValid && memReqReady} - {4'h0, memDone};
  end
  reset_quiet_a: assert property (disable iff (1'b0)
    reset |=> !memReqValid && !ldDoneValid && !dcWrValid && !wcWrValid)
    else $error("outputs active after reset");
  req_hold_a: assert property (memReqValid && !memReqReady |=>
    memReqValid && $stable(memReqAddr))
    else $error("request dropped or changed before ready");
  line_align_a: assert property (memReqValid |-> memReqAddr[5:0] == 6'h00)
    else $error("request address not line aligned");
  l2_fill_a: assert property (memReqValid && memReqToL2 |->
    !memReqModified && !memReqWay0)
    else $error("hardware prefetch carries first-level flags");
  nt_way_a: assert property (memReqValid && memReqWay0 |->
    memReqNoL2Evict && !memReqToL2)
    else $error("way 0 fill without no-evict flag");
  in_flight_a: assert property (inFlight <= PF_MAX)
    else $error("too many requests in flight");
  retire_write_a: assert property (dcWrValid || wcWrValid |-> $past(stRetire))
    else $error("store write without retire");
  one_path_a: assert property (wcWrValid |-> !dcWrValid)
    else $error("streaming store also wrote the cache");
  fwd_done_a: assert property (ldDoneForward |-> ldDoneValid)
    else $error("forward flag without load answer");
  cover property (ldDoneForward);
  cover property (memReqValid && memReqToL2);
  cover property (memReqValid && !memReqReady);
endmodule
bind sfpu_unit sfpu_unit_monitor #(.ADDR_W(ADDR_W), .PF_MAX(PF_MAX)) mon (
  .sys_clk(sys_clk), .reset(reset), .stRetire(stRetire), .dcWrValid(dcWrValid),
  .wcWrValid(wcWrValid), .ldDoneValid(ldDoneValid), .ldDoneForward(ldDoneForward),
  .memReqValid(memReqValid), .memReqAddr(memReqAddr), .memReqToL2(memReqToL2),
  .memReqModified(memReqModified), .memReqWay0(memReqWay0),
  .memReqNoL2Evict(memReqNoL2Evict), .memReqReady(memReqReady), .memDone(memDone));

/* File: verification/sfpu_mem_model.sv */
// Memory request path model: accepts requests, completes them in order
`timescale 1ns/1ps
module sfpu_mem_model #(
  parameter int LAT = 4
) (
  // Clock, reset and test controls
  input wire sys_clk,
  input wire reset,
  input wire slow,
  input wire hold,
  // Request handshake and completion
  input wire memReqValid,
  output logic memReqReady,
  output logic memDone
);
  int t = 0;
  int q[$];
  // Slow mode drops ready two cycles in three; hold starves completions
  always @(posedge sys_clk) begin
    t <= t + 1;
    memDone <= 1'b0;
    if (reset) begin
      q.delete();
      memReqReady <= 1'b0;
    end else begin
      memReqReady <= slow ? ((t % 3) == 0) : 1'b1;
      if (memReqValid && memReqReady) q.push_back(t);
      if (!hold && q.size() > 0 && t - q[0] >= LAT) begin
        memDone <= 1'b1;
        void'(q.pop_front());
      end
    end
  end
endmodule

/* File: verification/tb_store_forward_and_prefetch_unit.sv */
// Self-checking bench for the store-forward and prefetch unit
`timescale 1ns/1ps
`include "sfpu_consts.vh"
module tb_store_forward_and_prefetch_unit;
  localparam logic [47:0] A = 48'h1000;
  logic sys_clk = 1'b0, reset = 1'b1, stIssueValid = 1'b0, stIssueHighByte = 1'b0;
  logic stIssueStreaming = 1'b0, stRetire = 1'b0, ldValid = 1'b0, pfValid = 1'b0;
  logic accValid = 1'b0, slow = 1'b0, hold = 1'b0, memReqReady, memDone;
  logic [47:0] stIssueAddr = 48'h0, ldAddr = 48'h0, pfAddr = 48'h0, accAddr = 48'h0;
  logic [1:0] stIssueSize = 2'h0, ldSize = 2'h0, dcWrSize, wcWrSize;
  logic [63:0] stIssueData = 64'h0, dcWrData, wcWrData, ldDoneData;
  logic [2:0] pfOp = 3'h0;
  logic stReady, dcWrValid, wcWrValid, ldReady, ldDoneValid, ldDoneForward, pfReady;
  logic memReqValid, memReqToL2, memReqModified, memReqWay0, memReqNoL2Evict;
  logic [47:0] dcWrAddr, wcWrAddr, memReqAddr;
  logic [127:0] ldQ[$], wrQ[$], rqQ[$];
  logic [15:0] seed = 16'h7287;
  int fails = 0, n_checks = 0;
  sfpu_unit uut (.*);
  sfpu_mem_model mem (.sys_clk(sys_clk), .reset(reset), .slow(slow), .hold(hold),
    .memReqValid(memReqValid), .memReqReady(memReqReady), .memDone(memDone));
  // Clock of 100 ns period
  always #50 sys_clk = ~sys_clk;
  function automatic logic [63:0] rnd();
    for (int i = 0; i < 4; i++) begin
      seed = {seed[14:0], ^(seed & 16'hB400)};
      rnd = {rnd[47:0], seed};
    end
  endfunction
  // Bytes kept by a load of size s; size 3 wraps to all ones
  function automatic logic [63:0] msk(input logic [1:0] s);
    msk = (64'h1 << (7'h08 << s)) - 64'h1;
  endfunction
  // An empty queue yields a value no result can match
  function automatic logic [127:0] pk(ref logic [127:0] q[$]);
    pk = q.size() ? q.pop_front() : ~128'h0;
  endfunction
  task automatic cmp(input logic [127:0] g, input logic [127:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    if (ldQ.size() + wrQ.size() + rqQ.size() != 0) fails++;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic st(input logic [47:0] a, input logic [1:0] s, input logic hi, nt,
      input logic [63:0] d);
    wrQ.push_back({13'h0, nt, a, s, d});
    stIssueValid <= 1'b1;
    stIssueAddr <= a;
    stIssueSize <= s;
    stIssueHighByte <= hi;
    stIssueStreaming <= nt;
    stIssueData <= d;
    do @(posedge sys_clk); while (stReady !== 1'b1);
    stIssueValid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic ld(input logic [47:0] a, input logic [1:0] s, input logic [65:0] e);
    ldQ.push_back({62'h0, e});
    ldValid <= 1'b1;
    ldAddr <= a;
    ldSize <= s;
    do @(posedge sys_clk); while (ldReady !== 1'b1);
    ldValid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic ret();
    stRetire <= 1'b1;
    @(posedge sys_clk);
    stRetire <= 1'b0;
    clk(3);
  endtask
  // k: 10 forwarded, 01 waits for the store's cache write, 00 no match
  task automatic cs(input logic [47:0] sa, input logic [1:0] ss, input logic hi,
      input logic [47:0] la, input logic [1:0] ls, input logic [1:0] k);
    logic [63:0] d;
    d = rnd();
    st(sa, ss, hi, 1'b0, d);
    ld(la, ls, {k, k[1] ? d & msk(ls) : 64'h0});
    clk(3);
    ret();
  endtask
  task automatic pf(input logic [2:0] op, input logic [47:0] a);
    rqQ.push_back({76'h0, a[47:6], 6'h00, 1'b0, op == `SFPU_OP_MODIFY, op == `SFPU_OP_NTA,
      op == `SFPU_OP_NTA});
    pfValid <= 1'b1;
    pfOp <= op;
    pfAddr <= a;
    do @(posedge sys_clk); while (pfReady !== 1'b1);
    pfValid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic hw(input logic [47:0] a);
    accValid <= 1'b1;
    accAddr <= a;
    @(posedge sys_clk);
    accValid <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Result watcher: oldest note against each result that appears
  always @(posedge sys_clk) begin
    if (!reset && ldDoneValid)
      cmp({62'h0, ldDoneForward, dcWrValid, ldDoneForward ? ldDoneData : 64'h0},
        pk(ldQ));
    if (!reset && (dcWrValid || wcWrValid))
      cmp(wcWrValid ? {13'h0, 1'b1, wcWrAddr, wcWrSize, wcWrData}
        : {13'h0, 1'b0, dcWrAddr, dcWrSize, dcWrData}, pk(wrQ));
    if (!reset && memReqValid && memReqReady)
      cmp({76'h0, memReqAddr, memReqToL2, memReqModified, memReqWay0, memReqNoL2Evict},
        pk(rqQ));
  end
  initial begin
    logic [63:0] d;
    clk(5);
    reset <= 1'b0;
    clk(2);
    cs(A, 2'h3, 1'b0, A, 2'h3, 2'b10);
    cs(A + 48'h1, 2'h0, 1'b0, A, 2'h2, 2'b01);
    cs(A, 2'h3, 1'b0, A + 48'h2, 2'h1, 2'b01);
    cs(A + 48'h4, 2'h3, 1'b0, A + 48'h4, 2'h2, 2'b01);
    cs(A, 2'h0, 1'b1, A, 2'h0, 2'b01);
    cs(A, 2'h3, 1'b0, A, 2'h2, 2'b10);
    cs(A + 48'h3, 2'h0, 1'b0, A, 2'h0, 2'b01);
    cs(A + 48'h3000, 2'h2, 1'b0, A, 2'h2, 2'b01);
    cs(A + 48'h40, 2'h2, 1'b0, A, 2'h2, 2'b00);
    cs(A + 48'h2, 2'h1, 1'b0, A + 48'h2, 2'h1, 2'b10);
    d = rnd();
    st(A, 2'h0, 1'b1, 1'b0, ~d);
    st(A, 2'h3, 1'b0, 1'b0, d);
    ld(A, 2'h3, {2'b10, d});
    ret();
    ret();
    st(A + 48'h80, 2'h3, 1'b0, 1'b1, d);
    ret();
    // Every software op, each at a fully random address
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      pf(i[2:0], d[47:0]);
    end
    clk(20);
    // Descending and skipping pairs first, then one rising pair
    hw(48'h6040);
    hw(48'h6000);
    hw(48'h7000);
    hw(48'h7080);
    rqQ.push_back({76'h0, 48'h80C0, 4'b1000});
    hw(48'h8000);
    hw(48'h8040);
    clk(10);
    slow <= 1'b1;
    hold <= 1'b1;
    for (int i = 0; i < 8; i++) pf(3'h0, 48'h9000 + 48'(i * 64));
    clk(40);
    cmp({127'h0, pfReady}, 128'h0);
    hold <= 1'b0;
    pf(`SFPU_OP_MODIFY, 48'h9230);
    clk(30);
    close_out();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    clk(3000);
    fails++;
    close_out();
  end
endmodule
